//--- common/imdhu_pkg.sv
// Constants and types shared by the integer multiply/divide unit
package imdhu_pkg;

    // ========================================================================
    // Widths and instruction field layout
    // ========================================================================
    localparam int unsigned DW      = 64;
    localparam int unsigned WW      = 32;
    localparam int unsigned OPC_HI  = 31;
    localparam int unsigned OPC_LO  = 26;
    localparam int unsigned PAD_HI  = 15;
    localparam int unsigned PAD_LO  = 6;
    localparam int unsigned FN_HI   = 5;

    // ========================================================================
    // Encodings
    // ========================================================================
    localparam logic [5:0] OPC_SPECIAL = 6'h00;
    localparam logic [9:0] PAD_ZERO    = 10'h000;
    localparam logic [5:0] FN_UDD      = 6'h1f;
    localparam logic [5:0] FN_SDW      = 6'h1a;
    localparam logic [5:0] FN_UDW      = 6'h1b;
    localparam logic [5:0] FN_SMD      = 6'h1c;

    // ========================================================================
    // Reset values and timing counts
    // ========================================================================
    localparam logic [63:0] HILO_RST  = 64'h0000_0000_0000_0000;
    localparam logic [5:0]  DIV_LAST  = 6'h3f;
    localparam int          DIV_BOUND = 70;

    // ========================================================================
    // Types
    // ========================================================================
    typedef enum logic [2:0] {
        OP_NONE = 3'h0,
        OP_UDD  = 3'h1,
        OP_SDW  = 3'h2,
        OP_UDW  = 3'h3,
        OP_SMD  = 3'h4
    } imdhu_op_e;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_MUL  = 3'b010,
        ST_DIV  = 3'b100
    } imdhu_state_e;

endpackage

//--- rtl/imdhu_divider.sv
// Radix-2 restoring unsigned 64-bit divider, one quotient bit per clock
`timescale 1ns/1ps
`default_nettype none
module imdhu_divider (
    input  wire logic                      i_mclk,
    input  wire logic                      i_nrst,
    input  wire logic                      i_start,
    input  wire logic [imdhu_pkg::DW-1:0]  i_dividend,
    input  wire logic [imdhu_pkg::DW-1:0]  i_divisor,
    output logic                           o_done,
    output logic      [imdhu_pkg::DW-1:0]  o_quot,
    output logic      [imdhu_pkg::DW-1:0]  o_rem
);
    import imdhu_pkg::*;

    // ========================================================================
    // Iteration state
    // ========================================================================
    logic [DW-1:0] quot;
    logic [DW-1:0] rem;
    logic [DW-1:0] dvs;
    logic [5:0]    cnt;
    logic          run;
    logic          done;
    logic [DW-1:0] next_quot;
    logic [DW-1:0] next_rem;
    logic [DW-1:0] next_dvs;
    logic [5:0]    next_cnt;
    logic          next_run;
    logic          next_done;
    logic [DW:0]   trial;

    // Zero divisor needs no special case: it yields all ones and the dividend
    always_comb begin
        next_quot = quot;
        next_rem  = rem;
        next_dvs  = dvs;
        next_cnt  = cnt;
        next_run  = run;
        next_done = 1'b0;
        trial     = {rem, quot[DW-1]} - {1'b0, dvs};
        if (i_start) begin
            next_quot = i_dividend;
            next_rem  = HILO_RST;
            next_dvs  = i_divisor;
            next_cnt  = '0;
            next_run  = 1'b1;
        end else if (run) begin
            if (!trial[DW]) begin
                next_rem  = trial[DW-1:0];
                next_quot = {quot[DW-2:0], 1'b1};
            end else begin
                next_rem  = {rem[DW-2:0], quot[DW-1]};
                next_quot = {quot[DW-2:0], 1'b0};
            end
            next_cnt = cnt + 6'h01;
            if (cnt == DIV_LAST) begin
                next_run  = 1'b0;
                next_done = 1'b1;
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            quot <= HILO_RST;
            rem  <= HILO_RST;
            dvs  <= HILO_RST;
            cnt  <= '0;
            run  <= 1'b0;
            done <= 1'b0;
        end else begin
            quot <= next_quot;
            rem  <= next_rem;
            dvs  <= next_dvs;
            cnt  <= next_cnt;
            run  <= next_run;
            done <= next_done;
        end
    end

    assign o_done = done;
    assign o_quot = quot;
    assign o_rem  = rem;
endmodule
`default_nettype wire

//--- rtl/imdhu_unit.sv
// Integer multiply/divide unit with high and low result registers
// ============================================================================
// Summary of operation
// - Operations decode under the all-zero primary opcode with bits 15..6 zero; the function field picks one.
// - Unsigned doubleword divide puts the 64-bit quotient in the low, the remainder in the high result register.
// - Signed word divide uses the low 32 bits as signed and writes sign-extended quotient low, remainder high.
// - Unsigned word divide uses the low 32 bits as unsigned and writes both results sign-extended to 64 bits.
// - Signed doubleword multiply writes product bits 63..0 to the low and 127..64 to the high result register.
// - No multiply or divide raises an arithmetic exception, neither on overflow nor on a zero divisor.
// - A zero divisor leaves any value in the result registers and signals no trap.
// - The unit runs concurrently and stalls any result register read until the result is written.
// ============================================================================
`timescale 1ns/1ps
`default_nettype none
module imdhu_unit (
    input  wire logic                      i_mclk,
    input  wire logic                      i_nrst,
    input  wire logic                      i_issue,
    input  wire logic [31:0]               i_instr,
    input  wire logic [imdhu_pkg::DW-1:0]  i_op_a,
    input  wire logic [imdhu_pkg::DW-1:0]  i_op_b,
    input  wire logic                      i_mode64,
    input  wire logic                      i_read_hi,
    input  wire logic                      i_read_lo,
    output logic                           o_ready,
    output logic                           o_accept,
    output logic                           o_stall,
    output logic                           o_ri_exc,
    output logic      [imdhu_pkg::DW-1:0]  o_hi,
    output logic      [imdhu_pkg::DW-1:0]  o_lo
);
    import imdhu_pkg::*;

    // ========================================================================
    // Decode helpers
    // ========================================================================
    function automatic imdhu_op_e decode_op(input logic [31:0] ins);
        imdhu_op_e op;
        op = OP_NONE;
        if (ins[OPC_HI:OPC_LO] == OPC_SPECIAL && ins[PAD_HI:PAD_LO] == PAD_ZERO) begin
            case (ins[FN_HI:0])
                FN_UDD:  op = OP_UDD;
                FN_SDW:  op = OP_SDW;
                FN_UDW:  op = OP_UDW;
                FN_SMD:  op = OP_SMD;
                default: op = OP_NONE;
            endcase
        end
        return op;
    endfunction

    function automatic logic [DW-1:0] sext32(input logic [WW-1:0] v);
        return {{WW{v[WW-1]}}, v};
    endfunction

    function automatic logic [DW-1:0] abs32(input logic [WW-1:0] v);
        logic [WW-1:0] m;
        m = v[WW-1] ? -v : v;
        return {{WW{1'b0}}, m};
    endfunction

    // ========================================================================
    // State
    // ========================================================================
    imdhu_state_e         state;
    imdhu_state_e         next_state;
    imdhu_op_e            lat_op;
    imdhu_op_e            next_lat_op;
    logic [DW-1:0]        lat_a;
    logic [DW-1:0]        lat_b;
    logic [DW-1:0]        next_lat_a;
    logic [DW-1:0]        next_lat_b;
    logic [DW-1:0]        hi;
    logic [DW-1:0]        lo;
    logic [DW-1:0]        next_hi;
    logic [DW-1:0]        next_lo;
    logic                 ri_exc;
    logic                 next_ri_exc;
    imdhu_op_e            op_in;
    logic                 dbl_in;
    logic                 take;
    logic                 div_start;
    logic [DW-1:0]        div_a;
    logic [DW-1:0]        div_b;
    logic                 div_done;
    logic [DW-1:0]        div_q;
    logic [DW-1:0]        div_r;
    logic [WW-1:0]        q32;
    logic [WW-1:0]        r32;
    logic signed [127:0]  prod;

    assign op_in    = decode_op(i_instr);
    assign dbl_in   = (op_in == OP_UDD) || (op_in == OP_SMD);
    assign o_ready  = (state == ST_IDLE);
    assign take     = i_issue && o_ready && (op_in != OP_NONE) && !(dbl_in && !i_mode64);
    assign o_accept = take;
    // Reads wait while a result is still being produced
    assign o_stall  = (i_read_hi || i_read_lo) && (state != ST_IDLE);

    // Signed word divide runs on magnitudes; signs are restored on write-back
    always_comb begin
        div_a = {{WW{1'b0}}, i_op_a[WW-1:0]};
        div_b = {{WW{1'b0}}, i_op_b[WW-1:0]};
        if (op_in == OP_UDD) begin
            div_a = i_op_a;
            div_b = i_op_b;
        end else if (op_in == OP_SDW) begin
            div_a = abs32(i_op_a[WW-1:0]);
            div_b = abs32(i_op_b[WW-1:0]);
        end
    end

    assign div_start = take && (op_in != OP_SMD);

    imdhu_divider u_div (
        .i_mclk     (i_mclk),
        .i_nrst     (i_nrst),
        .i_start    (div_start),
        .i_dividend (div_a),
        .i_divisor  (div_b),
        .o_done     (div_done),
        .o_quot     (div_q),
        .o_rem      (div_r)
    );

    // Full-width product; one cycle keeps the control simple at 25 MHz
    assign prod = $signed(lat_a) * $signed(lat_b);

    always_comb begin
        q32 = div_q[WW-1:0];
        r32 = div_r[WW-1:0];
        if (lat_op == OP_SDW) begin
            if (lat_a[WW-1] ^ lat_b[WW-1]) begin
                q32 = -div_q[WW-1:0];
            end
            if (lat_a[WW-1]) begin
                r32 = -div_r[WW-1:0];
            end
        end
    end

    // ========================================================================
    // Sequencing and result registers
    // ========================================================================
    always_comb begin
        next_state  = state;
        next_lat_op = lat_op;
        next_lat_a  = lat_a;
        next_lat_b  = lat_b;
        next_hi     = hi;
        next_lo     = lo;
        // Only the mode check traps; arithmetic never does
        next_ri_exc = i_issue && o_ready && dbl_in && !i_mode64;
        case (state)
            ST_IDLE: begin
                if (take) begin
                    next_lat_op = op_in;
                    next_lat_a  = i_op_a;
                    next_lat_b  = i_op_b;
                    next_state  = (op_in == OP_SMD) ? ST_MUL : ST_DIV;
                end
            end
            ST_MUL: begin
                next_lo    = prod[63:0];
                next_hi    = prod[127:64];
                next_state = ST_IDLE;
            end
            ST_DIV: begin
                if (div_done) begin
                    if (lat_op == OP_UDD) begin
                        next_lo = div_q;
                        next_hi = div_r;
                    end else begin
                        next_lo = sext32(q32);
                        next_hi = sext32(r32);
                    end
                    next_state = ST_IDLE;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            state  <= ST_IDLE;
            lat_op <= OP_NONE;
            lat_a  <= HILO_RST;
            lat_b  <= HILO_RST;
            hi     <= HILO_RST;
            lo     <= HILO_RST;
            ri_exc <= 1'b0;
        end else begin
            state  <= next_state;
            lat_op <= next_lat_op;
            lat_a  <= next_lat_a;
            lat_b  <= next_lat_b;
            hi     <= next_hi;
            lo     <= next_lo;
            ri_exc <= next_ri_exc;
        end
    end

    assign o_hi     = hi;
    assign o_lo     = lo;
    assign o_ri_exc = ri_exc;

    // ========================================================================
    // Checks
    // ========================================================================
    logic fin;
    assign fin = (state == ST_DIV) && div_done;

    // Latest cycle at which a zero-divisor divide must be back to idle
    localparam int DIV_SPAN = DIV_BOUND;

    decode_gate_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        o_accept |-> i_instr[OPC_HI:OPC_LO] == OPC_SPECIAL && i_instr[PAD_HI:PAD_LO] == PAD_ZERO)
        else $error("accepted a non-matching encoding");

    udd_result_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        fin && lat_op == OP_UDD && lat_b != HILO_RST
        |=> lo == $past(lat_a) / $past(lat_b) && hi == $past(lat_a) % $past(lat_b))
        else $error("unsigned doubleword divide result wrong");

    sdw_result_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        fin && lat_op == OP_SDW && lat_b[WW-1:0] != '0 && lat_a[WW-1:0] != 32'h8000_0000
        |=> lo == sext32($signed($past(lat_a[WW-1:0])) / $signed($past(lat_b[WW-1:0])))
         && hi == sext32($signed($past(lat_a[WW-1:0])) % $signed($past(lat_b[WW-1:0]))))
        else $error("signed word divide result wrong");

    udw_result_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        fin && lat_op == OP_UDW && lat_b[WW-1:0] != '0
        |=> lo == sext32($past(lat_a[WW-1:0]) / $past(lat_b[WW-1:0]))
         && hi == sext32($past(lat_a[WW-1:0]) % $past(lat_b[WW-1:0])))
        else $error("unsigned word divide result wrong");

    smd_result_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        o_accept && op_in == OP_SMD
        |-> ##2 $signed({hi, lo}) == $signed($past(i_op_a, 2)) * $signed($past(i_op_b, 2)))
        else $error("signed doubleword multiply result wrong");

    no_arith_trap_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        o_ri_exc |-> $past(i_issue && o_ready && dbl_in && !i_mode64))
        else $error("exception raised without a mode violation");

    zero_div_done_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        div_start && div_b == HILO_RST |=> !o_ri_exc ##[64:DIV_SPAN] state == ST_IDLE)
        else $error("zero-divisor divide did not complete");

    read_stall_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        (i_read_hi || i_read_lo) && state != ST_IDLE |-> o_stall)
        else $error("result read not interlocked");

    read_value_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        (i_read_hi || i_read_lo) && !o_stall |=> $stable(o_hi) && $stable(o_lo))
        else $error("unstalled read saw a result still changing");

    mode_trap_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        i_issue && o_ready && dbl_in && !i_mode64 |-> !o_accept ##1 o_ri_exc && state == ST_IDLE)
        else $error("64-bit operation not trapped when disabled");
endmodule
`default_nettype wire

//--- bench/imdhu_pipe_model.sv
// Pipeline-side model: issues operations and reads the result registers
`timescale 1ns/1ps
`default_nettype none
module imdhu_pipe_model (
    input  wire logic                     i_mclk,
    input  wire logic                     i_ready,
    input  wire logic                     i_accept,
    input  wire logic                     i_stall,
    input  wire logic [imdhu_pkg::DW-1:0] i_hi,
    input  wire logic [imdhu_pkg::DW-1:0] i_lo,
    output var  logic                     o_issue,
    output var  logic [31:0]              o_instr,
    output var  logic [imdhu_pkg::DW-1:0] o_op_a,
    output var  logic [imdhu_pkg::DW-1:0] o_op_b,
    output var  logic                     o_mode64,
    output var  logic                     o_read_hi,
    output var  logic                     o_read_lo
);
    import imdhu_pkg::*;
    initial begin
        o_issue   = 1'b0;
        o_instr   = '0;
        o_op_a    = '0;
        o_op_b    = '0;
        o_mode64  = 1'b1;
        o_read_hi = 1'b0;
        o_read_lo = 1'b0;
    end
    // ========================================================================
    // Issue: hold the request until taken, or until refused while idle
    // ========================================================================
    task automatic issue(input logic [31:0] ins, input logic [DW-1:0] a, input logic [DW-1:0] b,
                         input logic m64, output logic acc, output int waits);
        logic fin;
        logic wd;
        wd = (ins[5:0] == FN_SDW) || (ins[5:0] == FN_UDW);
        acc = 1'b0;
        fin = 1'b0;
        waits = 0;
        o_issue  <= 1'b1;
        o_instr  <= ins;
        o_mode64 <= m64;
        o_op_a   <= wd ? {{WW{a[WW-1]}}, a[WW-1:0]} : a;
        o_op_b   <= wd ? {{WW{b[WW-1]}}, b[WW-1:0]} : b;
        while (!fin && waits < 200) begin
            @(negedge i_mclk);
            acc = (i_accept === 1'b1);
            fin = acc || (i_ready === 1'b1);
            if (!fin)
                waits++;
            @(posedge i_mclk);
        end
        // Released lines change so a stale value is never read as valid
        o_issue <= 1'b0;
        o_instr <= ~ins;
        o_op_a  <= ~o_op_a;
        o_op_b  <= ~o_op_b;
    endtask
    // ========================================================================
    // Read both result registers, holding while stalled
    // ========================================================================
    task automatic read(output logic [DW-1:0] hi, output logic [DW-1:0] lo, output int stalls);
        stalls = 0;
        o_read_hi <= 1'b1;
        o_read_lo <= 1'b1;
        @(negedge i_mclk);
        while (i_stall !== 1'b0 && stalls < 200) begin
            stalls++;
            @(negedge i_mclk);
        end
        hi = i_hi;
        lo = i_lo;
        @(posedge i_mclk);
        o_read_hi <= 1'b0;
        o_read_lo <= 1'b0;
        repeat (2) @(posedge i_mclk);
    endtask
endmodule
`default_nettype wire

//--- bench/imdhu_unit_bench.sv
// Self-checking bench for the integer multiply/divide unit
`timescale 1ns/1ps
`default_nettype none
module imdhu_unit_bench;
    import imdhu_pkg::*;
    logic        i_mclk = 1'b0;
    logic        i_nrst = 1'b0;
    logic        issue, mode64, read_hi, read_lo, ready, accept, stall, ri_exc;
    logic [31:0] instr;
    logic [63:0] op_a, op_b, hi, lo, m_hi, m_lo, seed, ra, rb;
    int          err_total, cmp_count, exp_ri, ri_seen;
    logic [5:0]  fns [4] = '{FN_UDD, FN_SDW, FN_UDW, FN_SMD};
    logic [5:0]  d_fn [7] = '{FN_UDD, FN_UDW, FN_SDW, FN_UDW, FN_SMD, FN_SMD, FN_SDW};
    logic [63:0] d_a [7] = '{64'hFEDC_BA98_7654_3210, 64'h0000_0000_1234_5678, 64'hFFFF_FFFF_8000_0000,
                             64'hFFFF_FFFF_FFFF_FFFF, 64'h8000_0000_0000_0000, 64'hFFFF_FFFF_FFFF_FFFF,
                             64'hFFFF_FFFF_8765_4321};
    logic [63:0] d_b [7] = '{64'h0000_0000_0000_0000, 64'h0000_0000_0000_0000, 64'hFFFF_FFFF_FFFF_FFFF,
                             64'h0000_0000_0000_0007, 64'h8000_0000_0000_0000, 64'h0000_0000_0000_0003,
                             64'h0000_0000_0000_0000};
    logic [5:0]  bad_op [5] = '{6'h01, 6'h00, 6'h00, 6'h00, 6'h00};
    logic [9:0]  bad_pd [5] = '{10'h000, 10'h001, 10'h200, 10'h000, 10'h000};
    logic [5:0]  bad_fn [5] = '{FN_SMD, FN_SMD, FN_UDD, 6'h1d, 6'h1e};

    always #20 i_mclk = ~i_mclk;
    always @(negedge i_mclk)
        if (ri_exc === 1'b1)
            ri_seen++;

    imdhu_unit dut (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_issue(issue), .i_instr(instr), .i_op_a(op_a),
        .i_op_b(op_b), .i_mode64(mode64), .i_read_hi(read_hi), .i_read_lo(read_lo), .o_ready(ready),
        .o_accept(accept), .o_stall(stall), .o_ri_exc(ri_exc), .o_hi(hi), .o_lo(lo));
    imdhu_pipe_model pipe (.i_mclk(i_mclk), .i_ready(ready), .i_accept(accept), .i_stall(stall),
        .i_hi(hi), .i_lo(lo), .o_issue(issue), .o_instr(instr), .o_op_a(op_a), .o_op_b(op_b),
        .o_mode64(mode64), .o_read_hi(read_hi), .o_read_lo(read_lo));

    function automatic logic [63:0] lfsr_next(input logic [63:0] s);
        return {s[62:0], s[63] ^ s[62] ^ s[60] ^ s[59]};
    endfunction
    task automatic rnd(output logic [63:0] v);
        repeat (64) seed = lfsr_next(seed);
        v = seed;
    endtask
    task automatic cmp_val(input string nm, input logic [63:0] e, input logic [63:0] g);
        cmp_count++;
        if (g !== e) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cmp_bit(input string nm, input logic e, input logic g);
        cmp_count++;
        if (g !== e) begin
            err_total++;
            $display("ERROR %s expected %b seen %b", nm, e, g);
        end
    endtask
    // ========================================================================
    // Reference model; zero divisors follow the unit's chosen results
    // ========================================================================
    task automatic expect_op(input logic [5:0] fn, input logic [63:0] a, input logic [63:0] b);
        logic signed [127:0] p;
        logic [31:0]         q;
        logic [31:0]         r;
        q = '0;
        r = '0;
        if (fn == FN_UDD) begin
            m_lo = (b == '0) ? '1 : a / b;
            m_hi = (b == '0) ? a : a % b;
        end else if (fn == FN_SMD) begin
            p = $signed(a) * $signed(b);
            m_lo = p[63:0];
            m_hi = p[127:64];
        end else if (fn == FN_UDW) begin
            q = (b[31:0] == '0) ? '1 : a[31:0] / b[31:0];
            r = (b[31:0] == '0) ? a[31:0] : a[31:0] % b[31:0];
        end else if (b[31:0] == '0) begin
            q = a[31] ? 32'h0000_0001 : 32'hFFFF_FFFF;
            r = a[31:0];
        end else if (a[31:0] == 32'h8000_0000 && b[31:0] == 32'hFFFF_FFFF) begin
            q = a[31:0];
        end else begin
            q = $signed(a[31:0]) / $signed(b[31:0]);
            r = $signed(a[31:0]) % $signed(b[31:0]);
        end
        if (fn == FN_SDW || fn == FN_UDW) begin
            m_lo = {{32{q[31]}}, q};
            m_hi = {{32{r[31]}}, r};
        end
    endtask
    task automatic do_op(input logic [5:0] opc, input logic [9:0] pad, input logic [5:0] fn,
                         input logic [63:0] a, input logic [63:0] b, input logic m64, input int ew, input bit rd);
        logic        acc, ok;
        logic [63:0] gh, gl;
        int          w, st;
        ok = (opc == OPC_SPECIAL) && (pad == PAD_ZERO) && (fn inside {FN_UDD, FN_SDW, FN_UDW, FN_SMD});
        exp_ri += (ok && !m64 && (fn == FN_UDD || fn == FN_SMD)) ? 1 : 0;
        ok = ok && (m64 || fn == FN_SDW || fn == FN_UDW);
        pipe.issue({opc, seed[9:0], pad, fn}, a, b, m64, acc, w);
        cmp_bit("accept", ok, acc);
        cmp_val("issue_waits", 64'(ew), 64'(w));
        if (ok)
            expect_op(fn, a, b);
        if (rd) begin
            pipe.read(gh, gl, st);
            cmp_val("read_stalls", 64'(ok ? (fn == FN_SMD ? 1 : 65) : 0), 64'(st));
            cmp_val("high_result", m_hi, gh);
            cmp_val("low_result", m_lo, gl);
            if (ok && fn == FN_SMD)
                cmp_bit("mul_overflow", m_hi != {64{m_lo[63]}}, gh != {64{gl[63]}});
        end else begin
            // Let an edge pass so a following issue never reassigns the strobe in this time step
            @(posedge i_mclk);
        end
    endtask
    task automatic print_verdict;
        $display("Counts: %0d compared, %0d mismatched", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // ========================================================================
    // Main sequence
    // ========================================================================
    initial begin
        seed = 64'h0000_0000_0000_0046;
        m_hi = HILO_RST;
        m_lo = HILO_RST;
        repeat (2) @(posedge i_mclk);
        i_nrst <= 1'b1;
        @(posedge i_mclk);
        for (int i = 0; i < 5; i++)
            do_op(bad_op[i], bad_pd[i], bad_fn[i], 64'h0000_0000_0000_0005, 64'h0000_0000_0000_0003,
                  1'b1, 0, 1'b1);
        for (int i = 0; i < 4; i++)
            do_op(OPC_SPECIAL, PAD_ZERO, fns[i], d_a[0], d_b[3], 1'b0, 0, 1'b1);
        for (int i = 0; i < 7; i++)
            do_op(OPC_SPECIAL, PAD_ZERO, d_fn[i], d_a[i], d_b[i], 1'b1, 0, 1'b1);
        for (int i = 0; i < 12; i++) begin
            rnd(ra);
            rnd(rb);
            do_op(OPC_SPECIAL, PAD_ZERO, fns[i % 4], ra, rb, 1'b1, 0, 1'b1);
        end
        do_op(OPC_SPECIAL, PAD_ZERO, FN_UDD, ra, rb, 1'b1, 0, 1'b0);
        do_op(OPC_SPECIAL, PAD_ZERO, FN_SMD, rb, ra, 1'b1, 64, 1'b1);
        cmp_val("ri_pulses", 64'(exp_ri), 64'(ri_seen));
        print_verdict();
    end
    initial begin
        #800000;
        err_total++;
        print_verdict();
    end
endmodule
`default_nettype wire
